/* File: dcs_channel_sync.sv */
// dcs_channel_sync: lower control fields of a two-channel dram controller
// register port on core_clk; memory_clock is a foreign pin, sampled here
//
// The address map and the strobed register port were chosen for this implementation.
module dcs_channel_sync #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic memory_clock,
  input wire logic [DATA_W-1:0] northbridge_data,
  output logic [DATA_W-1:0] mem_data,
  output logic mem_valid,
  output logic phase_align,
  output dcs_pkg::dcs_setup_t ch0_setup,
  output dcs_pkg::dcs_setup_t ch1_setup,
  output dcs_pkg::dcs_turn_t turnaround
);

  localparam int PW = $clog2(DEPTH);

  // --------------------------------------------------------------------------
  // parameter checks
  // --------------------------------------------------------------------------
  // separation tops out below four memory clocks, so eight entries suffice
  if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 8");
  end
  if (DATA_W < 1) begin : g_bad_width
    $error("DATA_W must be at least 1");
  end

  // --------------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_reg, ctrl_next;
  logic [1:0] cfg_reg, cfg_next;
  logic [5:0] lowt_reg, lowt_next;
  logic [7:0] setup_reg, setup_next;
  logic [31:0] rdata_reg, rdata_next;
  logic start_req, stop_req;
  logic [31:0] status_word;

  // decode writes; start and stop are write-one pulses that store nothing
  always_comb begin
    ctrl_next = ctrl_reg;
    cfg_next = cfg_reg;
    lowt_next = lowt_reg;
    setup_next = setup_reg;
    start_req = 1'b0;
    stop_req = 1'b0;
    rdata_next = 32'h0000_0000;
    if (reg_write) begin
      case (reg_addr)
        dcs_pkg::OFS_CTRL: ctrl_next = reg_wdata & dcs_pkg::CTRL_WMASK;
        dcs_pkg::OFS_CFG: begin
          cfg_next = reg_wdata[1:0];
          start_req = reg_wdata[dcs_pkg::CFG_START];
          stop_req = reg_wdata[dcs_pkg::CFG_STOP];
        end
        dcs_pkg::OFS_LOWT: lowt_next = reg_wdata[5:0];
        dcs_pkg::OFS_SETUP: setup_next = {1'b0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
        default: ;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        dcs_pkg::OFS_CTRL: rdata_next = ctrl_reg;
        dcs_pkg::OFS_CFG: rdata_next = {30'h0000_0000, cfg_reg};
        dcs_pkg::OFS_LOWT: rdata_next = {26'h000_0000, lowt_reg};
        dcs_pkg::OFS_SETUP: rdata_next = {24'h00_0000, setup_reg};
        dcs_pkg::OFS_STATUS: rdata_next = status_word;
        default: rdata_next = 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= dcs_pkg::CTRL_RESET;
      cfg_reg <= 2'b00;
      lowt_reg <= 6'b00_0000;
      setup_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      cfg_reg <= cfg_next;
      lowt_reg <= lowt_next;
      setup_reg <= setup_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // --------------------------------------------------------------------------
  // setup selection and turnaround assembly
  // --------------------------------------------------------------------------
  logic sync_en, ddr3_select, ganged;
  dcs_pkg::dcs_setup_t ch0_cfg, ch1_cfg;
  dcs_pkg::dcs_setup_t ch0_next, ch1_next;
  dcs_pkg::dcs_setup_t ch0_reg, ch1_reg;
  dcs_pkg::dcs_turn_t turn_next, turn_reg;
  logic align_next, align_reg;
  logic sync_missing;

  assign sync_en = ctrl_reg[dcs_pkg::CTRL_SYNC];
  assign ddr3_select = cfg_reg[dcs_pkg::CFG_DDR3];
  assign ganged = cfg_reg[dcs_pkg::CFG_GANGED];
  assign ch0_cfg = setup_reg[2:0];
  assign ch1_cfg = setup_reg[dcs_pkg::SETUP_CH1_LSB +: 3];

  // software is expected to set sync here; the flag only reports the miss
  assign sync_missing = ganged && !sync_en && // RULE3
    ((ch0_cfg == 3'b000 && ch1_cfg != 3'b000) || (ch1_cfg == 3'b000 && ch0_cfg != 3'b000));

  // pick setups and widen turnarounds; registered so outputs never glitch
  always_comb begin
    align_next = sync_en;
    if (sync_en) begin
      ch0_next = '0; // RULE1
      ch1_next = '0; // RULE1
    end else begin
      ch0_next = ch0_cfg; // RULE2
      ch1_next = ch1_cfg; // RULE2
    end
    if (ddr3_select) begin
      turn_next.read_to_read = {ctrl_reg[dcs_pkg::CTRL_RDRD_LSB +: 2],
        lowt_reg[dcs_pkg::LOWT_RDRD_LSB +: 2]}; // RULE4
      turn_next.write_to_write = {ctrl_reg[dcs_pkg::CTRL_WRWR_LSB +: 2],
        lowt_reg[dcs_pkg::LOWT_WRWR_LSB +: 2]}; // RULE5
      turn_next.write_to_read = {ctrl_reg[dcs_pkg::CTRL_WRRD_LSB +: 2],
        lowt_reg[dcs_pkg::LOWT_WRRD_LSB +: 2]}; // RULE6
    end else begin
      turn_next.read_to_read = {2'b00, lowt_reg[dcs_pkg::LOWT_RDRD_LSB +: 2]}; // RULE7
      turn_next.write_to_write = {2'b00, lowt_reg[dcs_pkg::LOWT_WRWR_LSB +: 2]}; // RULE7
      turn_next.write_to_read = {2'b00, lowt_reg[dcs_pkg::LOWT_WRRD_LSB +: 2]}; // RULE7
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ch0_reg <= '0;
      ch1_reg <= '0;
      turn_reg <= '0;
      align_reg <= 1'b0;
    end else begin
      ch0_reg <= ch0_next;
      ch1_reg <= ch1_next;
      turn_reg <= turn_next;
      align_reg <= align_next;
    end
  end

  assign ch0_setup = ch0_reg;
  assign ch1_setup = ch1_reg;
  assign turnaround = turn_reg;
  assign phase_align = align_reg;

  // --------------------------------------------------------------------------
  // memory clock sampling
  // --------------------------------------------------------------------------
  logic mclk_s1_reg, mclk_s2_reg, mclk_s3_reg;
  logic mclk_rise, mclk_edge;

  // first stage feeds only the second; edges come from stages two and three
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mclk_s1_reg <= 1'b0;
      mclk_s2_reg <= 1'b0;
      mclk_s3_reg <= 1'b0;
    end else begin
      mclk_s1_reg <= memory_clock;
      mclk_s2_reg <= mclk_s1_reg;
      mclk_s3_reg <= mclk_s2_reg;
    end
  end

  assign mclk_edge = mclk_s2_reg ^ mclk_s3_reg;
  assign mclk_rise = mclk_s2_reg & ~mclk_s3_reg;

  // --------------------------------------------------------------------------
  // northbridge to memory clock fifo
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_RISE, ST_RUN} dcs_fifo_state_t;

  dcs_fifo_state_t fstate_reg, fstate_next;
  logic [DATA_W-1:0] mem_reg [DEPTH];
  logic [DATA_W-1:0] mem_next [DEPTH];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [3:0] half_reg, half_next, sep_half_reg, sep_half_next;
  logic [3:0] code_reg, code_next;
  logic popped_reg, popped_next, odd_reg, odd_next;
  logic [DATA_W-1:0] out_reg, out_next;
  logic valid_reg, valid_next;
  logic [3:0] live_code, live_sep;
  logic code_reserved;

  assign live_code = ctrl_reg[dcs_pkg::CTRL_PTR_LSB +: 4];

  // each code step from 1 to 7 moves the read pointer half a clock closer
  always_comb begin
    if (live_code != 4'h0 && live_code < dcs_pkg::PTR_HALF_BASE) begin
      live_sep = dcs_pkg::PTR_HALF_BASE - live_code; // RULE8
    end else begin
      live_sep = dcs_pkg::PTR_HALF_MIN;
    end
  end

  // only 3, 4 and 5 are defined, and 3 not in ddr3; others are flagged
  assign code_reserved = !((live_code == dcs_pkg::PTR_CODE_2P5 && !ddr3_select) ||
    live_code == dcs_pkg::PTR_CODE_2P0 || live_code == dcs_pkg::PTR_CODE_1P5); // RULE9

  // the start code is taken once at start; later writes wait for a restart
  always_comb begin
    fstate_next = fstate_reg;
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    half_next = half_reg;
    sep_half_next = sep_half_reg;
    code_next = code_reg;
    popped_next = popped_reg;
    odd_next = odd_reg;
    out_next = out_reg;
    valid_next = 1'b0;
    case (fstate_reg)
      ST_IDLE: begin
        if (start_req) begin
          sep_half_next = live_sep; // RULE10
          code_next = live_code; // RULE10
          fstate_next = ST_WAIT_RISE;
        end
      end
      ST_WAIT_RISE: begin
        if (mclk_rise) begin
          mem_next[0] = northbridge_data;
          wr_ptr_next = PW'(1);
          rd_ptr_next = '0;
          half_next = 4'h0;
          popped_next = 1'b0;
          odd_next = 1'b0;
          fstate_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (mclk_edge) begin
          if (mclk_rise) begin
            mem_next[wr_ptr_reg] = northbridge_data; // writes land on rising edges only
            wr_ptr_next = wr_ptr_reg + PW'(1);
          end
          if (!popped_reg) begin
            half_next = half_reg + 4'h1;
            if (half_reg + 4'h1 == sep_half_reg) begin
              popped_next = 1'b1; // RULE8
              odd_next = 1'b1;
              out_next = mem_reg[rd_ptr_reg];
              valid_next = 1'b1;
              rd_ptr_next = rd_ptr_reg + PW'(1);
            end
          end else begin
            odd_next = ~odd_reg; // one read per full clock after the first
            if (!odd_reg) begin
              out_next = mem_reg[rd_ptr_reg];
              valid_next = 1'b1;
              rd_ptr_next = rd_ptr_reg + PW'(1);
            end
          end
        end
      end
      default: fstate_next = ST_IDLE;
    endcase
    if (stop_req) begin
      fstate_next = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fstate_reg <= ST_IDLE;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      half_reg <= 4'h0;
      sep_half_reg <= dcs_pkg::PTR_HALF_BASE - dcs_pkg::CTRL_RESET[3:0]; // matches reset code
      code_reg <= dcs_pkg::CTRL_RESET[3:0];
      popped_reg <= 1'b0;
      odd_reg <= 1'b0;
      out_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      fstate_reg <= fstate_next;
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      half_reg <= half_next;
      sep_half_reg <= sep_half_next;
      code_reg <= code_next;
      popped_reg <= popped_next;
      odd_reg <= odd_next;
      out_reg <= out_next;
      valid_reg <= valid_next;
    end
  end

  assign mem_data = out_reg;
  assign mem_valid = valid_reg;

  // status: running, reserved code, missing sync, latched code and separation
  assign status_word = {16'h0000, sep_half_reg, code_reg, 5'b0_0000,
    sync_missing, code_reserved, (fstate_reg == ST_RUN)};

endmodule : dcs_channel_sync

/* File: dcs_pkg.sv */
// dcs_pkg: constants, field layout and carrier types of the channel sync block
// assumes a 32-bit register port with byte offsets on word boundaries
// ----------------------------------------------------------------------------
// Summary of operation
// [RULE1] sync set: align memory clocks, ignore setups
// [RULE2] sync clear: use per-channel setup values
// [RULE3] software sets sync for mismatched ganged setups
// [RULE4] ddr3: bits 13:12 extend read-read turnaround
// [RULE5] ddr3: bits 11:10 extend write-write turnaround
// [RULE6] ddr3: bits 9:8 extend write-read turnaround
// [RULE7] not ddr3: upper turnaround bits ignored
// [RULE8] fifo start code: each step half clock
// [RULE9] codes 3,4,5 give 2.5,2,1.5 clocks
// [RULE10] program start code before init, keep default
// ----------------------------------------------------------------------------
package dcs_pkg;

  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_LOWT = 8'h08;
  localparam logic [7:0] OFS_SETUP = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // --------------------------------------------------------------------------
  // control register layout and reset
  // --------------------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0006;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_BF0F;
  localparam int CTRL_SYNC = 15;
  localparam int CTRL_RDRD_LSB = 12;
  localparam int CTRL_WRWR_LSB = 10;
  localparam int CTRL_WRRD_LSB = 8;
  localparam int CTRL_PTR_LSB = 0;

  // --------------------------------------------------------------------------
  // config, low-turnaround and setup register layouts
  // --------------------------------------------------------------------------
  localparam int CFG_DDR3 = 0;
  localparam int CFG_GANGED = 1;
  localparam int CFG_START = 2;
  localparam int CFG_STOP = 3;
  localparam int LOWT_RDRD_LSB = 0;
  localparam int LOWT_WRWR_LSB = 2;
  localparam int LOWT_WRRD_LSB = 4;
  localparam int SETUP_CH1_LSB = 4;

  // --------------------------------------------------------------------------
  // read pointer start codes
  // --------------------------------------------------------------------------
  localparam logic [3:0] PTR_CODE_2P5 = 4'h3;
  localparam logic [3:0] PTR_CODE_2P0 = 4'h4;
  localparam logic [3:0] PTR_CODE_1P5 = 4'h5;
  localparam logic [3:0] PTR_HALF_BASE = 4'h8;
  localparam logic [3:0] PTR_HALF_MIN = 4'h1;

  // per-channel setup fields: address/command, chip select/termination, clock enable
  typedef struct packed {
    logic clock_enable_setup;
    logic chipselect_termination_setup;
    logic address_command_setup;
  } dcs_setup_t;

  // effective 4-bit turnaround values
  typedef struct packed {
    logic [3:0] read_to_read;
    logic [3:0] write_to_write;
    logic [3:0] write_to_read;
  } dcs_turn_t;

endpackage : dcs_pkg

/* File: dcs_channel_sync_chk.sv */
// dcs_channel_sync_chk: port-level assertions for the channel sync block
// bound into dcs_channel_sync; sees its ports only
module dcs_channel_sync_chk #(
  parameter int DATA_W = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic memory_clock,
  input wire logic [DATA_W-1:0] northbridge_data,
  input wire logic [DATA_W-1:0] mem_data,
  input wire logic mem_valid,
  input wire logic phase_align,
  input wire dcs_pkg::dcs_setup_t ch0_setup,
  input wire dcs_pkg::dcs_setup_t ch1_setup,
  input wire dcs_pkg::dcs_turn_t turnaround
);
  // --------------------------------------------------------------------------
  // shadow of written state
  // --------------------------------------------------------------------------
  logic [31:0] ctl_reg, ctl_next;
  logic [5:0] lo_reg, lo_next;
  logic d3_reg, d3_next;
  dcs_pkg::dcs_turn_t exp_t;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // mirror taken at the write edge, as the register file does
  always_comb begin
    ctl_next = ctl_reg;
    lo_next = lo_reg;
    d3_next = d3_reg;
    if (reg_write && reg_addr == dcs_pkg::OFS_CTRL) ctl_next = reg_wdata & dcs_pkg::CTRL_WMASK;
    if (reg_write && reg_addr == dcs_pkg::OFS_LOWT) lo_next = reg_wdata[5:0];
    if (reg_write && reg_addr == dcs_pkg::OFS_CFG) d3_next = reg_wdata[0];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_reg <= dcs_pkg::CTRL_RESET;
      lo_reg <= 6'h00;
      d3_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      lo_reg <= lo_next;
      d3_reg <= d3_next;
    end
  end

  // upper bits only count in ddr3 mode
  assign exp_t.read_to_read = {d3_reg ? ctl_reg[13:12] : 2'b00, lo_reg[1:0]};
  assign exp_t.write_to_write = {d3_reg ? ctl_reg[11:10] : 2'b00, lo_reg[3:2]};
  assign exp_t.write_to_read = {d3_reg ? ctl_reg[9:8] : 2'b00, lo_reg[5:4]};

  sequence s_quiet;
    !reg_write;
  endsequence
  property p_sync;
    logic v;
    (reg_write && reg_addr == dcs_pkg::OFS_CTRL, v = reg_wdata[15]) |-> ##2 phase_align == v;
  endproperty
  property p_setup;
    logic [6:0] v;
    (reg_write && reg_addr == dcs_pkg::OFS_SETUP, v = reg_wdata[6:0]) ##1 s_quiet ##1
      !phase_align |-> ch0_setup == v[2:0] && ch1_setup == v[6:4];
  endproperty
  property p_rd;
    logic [31:0] v;
    (reg_read && reg_addr == dcs_pkg::OFS_CTRL, v = ctl_reg) |=> reg_rdata == v;
  endproperty

  a_sync_follow: assert property (p_sync)
    else $error("phase align does not follow sync bit");
  a_sync_zero: assert property (phase_align |-> ch0_setup == 3'b000 && ch1_setup == 3'b000)
    else $error("setups not ignored while aligned");
  a_setup_follow: assert property (p_setup)
    else $error("setups do not follow setup register");
  a_rdrd_turn: assert property (turnaround.read_to_read == $past(exp_t.read_to_read))
    else $error("read to read turnaround wrong");
  a_wrwr_turn: assert property (turnaround.write_to_write == $past(exp_t.write_to_write))
    else $error("write to write turnaround wrong");
  a_wrrd_turn: assert property (turnaround.write_to_read == $past(exp_t.write_to_read))
    else $error("write to read turnaround wrong");
  a_legacy_upper: assert property (!$past(d3_reg) |-> {turnaround.read_to_read[3:2],
    turnaround.write_to_write[3:2], turnaround.write_to_read[3:2]} == 6'h00)
    else $error("upper turnaround bits used outside ddr3");
  a_pop_spacing: assert property (mem_valid |=> !mem_valid [*6])
    else $error("pops closer than one memory clock");
  a_ctrl_read: assert property (p_rd)
    else $error("control read data wrong");
endmodule : dcs_channel_sync_chk

bind dcs_channel_sync dcs_channel_sync_chk #(.DATA_W(DATA_W)) u_chk (.core_clk(core_clk),
  .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .memory_clock(memory_clock),
  .northbridge_data(northbridge_data),
  .mem_data(mem_data), .mem_valid(mem_valid), .phase_align(phase_align),
  .ch0_setup(ch0_setup), .ch1_setup(ch1_setup), .turnaround(turnaround));

/* File: dcs_mem_model.sv */
// dcs_mem_model: memory side stand-in, free-running memory clock and word stream
// assumes a bench core clock with edges 1ns after each memory clock edge
module dcs_mem_model (
  output logic memory_clock,
  output logic [7:0] northbridge_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------------------
  // clock and data
  // --------------------------------------------------------------------------
  // 64 ns period; the odd offset keeps edges clear of core sampling
  initial begin
    memory_clock = 1'b0;
    #3;
    forever begin
      #32 memory_clock = ~memory_clock;
    end
  end

  // word is the rise count, so a popped word tells its own age
  initial northbridge_data = 8'h00;
  always @(posedge memory_clock) northbridge_data <= northbridge_data + 8'h01;
endmodule : dcs_mem_model

/* File: tb_top.sv */
// tb_top: self-checking bench for the channel sync block
// drives the register port on core_clk; memory side comes from dcs_mem_model
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------------------
  // signals, helpers, sequence
  // --------------------------------------------------------------------------
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic memory_clock;
  logic [7:0] northbridge_data, mem_data;
  logic mem_valid, phase_align;
  dcs_pkg::dcs_setup_t ch0_setup, ch1_setup;
  dcs_pkg::dcs_turn_t turnaround;
  int num_errors = 0;
  int tests_run = 0;
  logic hung = 1'b0;
  logic [31:0] rnd = 32'h75e0_62cd;
  logic [3:0] codes [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h0, 4'hF, 4'h3};

  always #4 core_clk = ~core_clk;

  dcs_mem_model u_mem (.memory_clock(memory_clock), .northbridge_data(northbridge_data));
  dcs_channel_sync #(.DATA_W(8), .DEPTH(8)) uut (.core_clk(core_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .memory_clock(memory_clock), .northbridge_data(northbridge_data),
    .mem_data(mem_data), .mem_valid(mem_valid), .phase_align(phase_align),
    .ch0_setup(ch0_setup), .ch1_setup(ch1_setup), .turnaround(turnaround));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction : lfsr
  // separation in half memory clocks; reserved codes still run
  function automatic logic [3:0] halves(input logic [3:0] c);
    return (c >= 4'h1 && c <= 4'h7) ? 4'h8 - c : 4'h1;
  endfunction : halves
  function automatic logic [11:0] turn(input logic [5:0] hi, input logic [5:0] lo, input logic d3);
    logic [5:0] h;
    h = d3 ? hi : 6'h00;
    return {h[5:4], lo[1:0], h[3:2], lo[3:2], h[1:0], lo[5:4]};
  endfunction : turn

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : rd
  // bounded wait for the next pop; a hang is counted and ends the scenario loop
  task automatic wait_valid();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (mem_valid !== 1'b1 && n < 300);
    if (mem_valid !== 1'b1) begin
      num_errors++;
      hung = 1'b1;
    end
  endtask : wait_valid

  initial begin
    logic [31:0] d, v;
    logic [3:0] c, h;
    logic d3;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(dcs_pkg::OFS_CTRL, d);
    check("ctrl reset", d, dcs_pkg::CTRL_RESET);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, d);
    check("unmapped", d, 32'h0000_0000);
    // turnaround merge in both modes, all-ones corner at the end
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      d3 = i[0];
      v = (i > 5) ? 32'hFFFF_7FFF : rnd & 32'hFFFF_7FFF;
      wr(dcs_pkg::OFS_CFG, {31'h0, d3});
      wr(dcs_pkg::OFS_LOWT, {26'h0, rnd[21:16]});
      wr(dcs_pkg::OFS_CTRL, v);
      repeat (2) @(posedge core_clk);
      d = {20'h0, turn(v[13:8], rnd[21:16], d3)};
      check("turnaround", {20'h0, turnaround}, d);
      rd(dcs_pkg::OFS_CTRL, d);
      check("ctrl read", d, v & dcs_pkg::CTRL_WMASK);
    end
    // ganged, one channel all zero, other not: sync off then on
    for (int s = 0; s < 2; s++) begin
      rnd = lfsr(rnd);
      v = {25'h0, 3'b001 | rnd[6:4], 4'h0};
      wr(dcs_pkg::OFS_CFG, 32'h0000_0002);
      wr(dcs_pkg::OFS_SETUP, v);
      wr(dcs_pkg::OFS_CTRL, {16'h0, s[0], 15'h0004});
      repeat (2) @(posedge core_clk);
      check("align", {31'h0, phase_align}, {31'h0, s[0]});
      d = s[0] ? 32'h0 : {26'h0, v[6:4], v[2:0]};
      check("setups", {26'h0, ch1_setup, ch0_setup}, d);
      rd(dcs_pkg::OFS_STATUS, d);
      check("sync missing", {31'h0, d[2]}, {31'h0, ~s[0]});
    end
    // fifo start codes: pop edge kind and word age show the separation
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      c = (i < 7) ? codes[i] : rnd[3:0];
      d3 = (i > 5);
      h = halves(c);
      wr(dcs_pkg::OFS_CTRL, {28'h0, c});
      wr(dcs_pkg::OFS_CFG, {28'h0, 3'b100, d3});
      wr(dcs_pkg::OFS_CFG, {28'h0, 3'b010, d3});
      wait_valid();
      if (hung) break;
      v = {23'h0, northbridge_data - mem_data, memory_clock};
      check("pop phase", v, {28'h0, h[3:1], ~h[0]});
      d = {24'h0, mem_data};
      wait_valid();
      if (hung) break;
      check("next pop", {24'h0, mem_data}, (d + 32'h1) & 32'h0000_00FF);
      rd(dcs_pkg::OFS_STATUS, v);
      d = {16'h0, h, c, 6'h0, !(c == 4'h4 || c == 4'h5 || (c == 4'h3 && !d3)), 1'b1};
      check("status", {16'h0, v[15:8], 6'h0, v[1:0]}, d);
    end
    final_report();
  end
endmodule : tb_top
